// ===== rtl/pecfg_ext_space.sv
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Extended area holds AER, VC, power budget
// - First extended capability header at 100h
// - Later capabilities all above 0FFh
// - Latency structure at 230h ends chain
// - Second VC resource control at 160h
// - Vendor identity read-only, loadable by sideband
module pecfg_ext_space
  import pecfg_pkg::*;
#(
  parameter logic [15:0] VENDOR_IDENTITY = VENDOR_DEFAULT  // Arbitrary value
) (
  input  wire logic          mclk,        // 25 MHz core clock
  input  wire logic          arst_n,      // Async reset, low
  input  wire pecfg_req_type cfgReq,      // Config request
  output pecfg_rsp_type      cfgRsp,      // Config answer
  input  wire logic          idLoad,      // Sideband id load
  input  wire logic [15:0]   idLoadVal,   // Loaded vendor_identity
  input  wire logic [31:0]   uncErrSet,   // Uncorrectable events
  input  wire logic [31:0]   corErrSet,   // Correctable events
  input  wire logic          hlogWe,      // Header log write
  input  wire logic [1:0]    hlogIdx,     // Header log word
  input  wire logic [31:0]   hlogData,    // Header log data
  output logic [31:0]        vc1Control,  // Channel 1 control
  output logic [31:0]        egressVec    // Egress vector
);

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rstMeta_r;
  logic rstN_r;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_r <= 1'b0;
      rstN_r    <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstN_r    <= rstMeta_r;
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0]   vendor;
    logic [31:0]   uncStat;
    logic [31:0]   uncMask;
    logic [31:0]   uncSev;
    logic [31:0]   corStat;
    logic [31:0]   corMask;
    logic [31:0]   aerCtrl;
    logic [31:0]   pvcCtrl;
    logic [31:0]   vc0Ctrl;
    logic [31:0]   vc1Ctrl;
    logic [31:0]   pwrSel;
    logic [31:0]   acsCtrl;
    logic [31:0]   egress;
    logic [31:0]   ltrLat;
    logic          strapped;
    logic          logPend;
    pecfg_rsp_type rsp;
  } pecfg_state_type;

  pecfg_state_type st_r;
  pecfg_state_type st_nxt;
  logic [31:0]     hlogRdata;

  // Header log words live in a small memory
  pecfg_hlog_mem #(.DEPTH(4)) uHlog (
    .mclk  (mclk),
    .rstN  (rstN_r),
    .we    (hlogWe),
    .waddr (hlogIdx),
    .wdata (hlogData),
    .raddr (cfgReq.addr[3:2] - 2'h3),
    .rdata (hlogRdata)
  );

  // Byte-enable merge for writable words
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // Write-one-to-clear with set winning
  function automatic logic [31:0] w1c(input logic [31:0] old,
                                      input logic [31:0] set,
                                      input logic [31:0] clr);
    w1c = (old & ~clr) | set;
  endfunction

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  logic [31:0] rdMux;
  logic        rdHit;
  logic        isLog;
  always_comb begin
    rdMux = RESET_ZERO;
    rdHit = 1'b1;
    isLog = ({cfgReq.addr[11:2], 2'b00} >= OFF_HLOG0)
         && ({cfgReq.addr[11:2], 2'b00} <= OFF_HLOG3);
    case ({cfgReq.addr[11:2], 2'b00})
      OFF_VENDOR:   rdMux = {16'h0000, st_r.vendor};
      OFF_AER_HDR:  rdMux = ext_hdr(CAPID_AER, OFF_VC_HDR);
      OFF_UNC_STAT: rdMux = st_r.uncStat;
      OFF_UNC_MASK: rdMux = st_r.uncMask;
      OFF_UNC_SEV:  rdMux = st_r.uncSev;
      OFF_COR_STAT: rdMux = st_r.corStat;
      OFF_COR_MASK: rdMux = st_r.corMask;
      OFF_AER_CTRL: rdMux = st_r.aerCtrl;
      OFF_VC_HDR:   rdMux = ext_hdr(CAPID_VC, OFF_PWR_HDR);
      OFF_PVC_CAP1: rdMux = {29'h0, VC_EXT_COUNT};
      OFF_PVC_CAP2: rdMux = RESET_ZERO;
      OFF_PVC_CTST: rdMux = st_r.pvcCtrl;
      OFF_VC0_CAP:  rdMux = RESET_ZERO;
      OFF_VC0_CTRL: rdMux = st_r.vc0Ctrl;
      OFF_VC0_STAT: rdMux = RESET_ZERO;
      OFF_VC1_CAP:  rdMux = RESET_ZERO;
      OFF_VC1_CTRL: rdMux = st_r.vc1Ctrl;
      OFF_VC1_STAT: rdMux = RESET_ZERO;
      OFF_PWR_HDR:  rdMux = ext_hdr(CAPID_PWR, OFF_ACS_HDR);
      OFF_PWR_SEL:  rdMux = st_r.pwrSel;
      OFF_PWR_CAP:  rdMux = RESET_ZERO;
      OFF_ACS_HDR:  rdMux = ext_hdr(CAPID_ACS, OFF_LTR_HDR);
      OFF_ACS_CTRL: rdMux = st_r.acsCtrl;
      OFF_EGRESS:   rdMux = st_r.egress;
      OFF_LTR_HDR:  rdMux = ext_hdr(CAPID_LTR, NEXT_END);
      OFF_LTR_LAT:  rdMux = st_r.ltrLat;
      default: begin
        rdHit = isLog;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic        wr;
  logic [11:0] wa;
  always_comb begin
    st_nxt = st_r;
    wr     = cfgReq.wr;
    wa     = {cfgReq.addr[11:2], 2'b00};
    // Strap default once after release, sideband may overwrite
    if (!st_r.strapped) begin
      st_nxt.vendor   = VENDOR_IDENTITY;
      st_nxt.strapped = 1'b1;
    end else if (idLoad) begin
      st_nxt.vendor = idLoadVal;
    end
    // Sticky error status, set wins over clear
    st_nxt.uncStat = w1c(st_r.uncStat, uncErrSet,
      (wr && wa == OFF_UNC_STAT) ? merge(RESET_ZERO, cfgReq.wdata,
                                         cfgReq.be) : RESET_ZERO);
    st_nxt.corStat = w1c(st_r.corStat, corErrSet,
      (wr && wa == OFF_COR_STAT) ? merge(RESET_ZERO, cfgReq.wdata,
                                         cfgReq.be) : RESET_ZERO);
    if (wr) begin
      case (wa)
        OFF_UNC_MASK: st_nxt.uncMask = merge(st_r.uncMask, cfgReq.wdata,
                                             cfgReq.be);
        OFF_UNC_SEV:  st_nxt.uncSev  = merge(st_r.uncSev, cfgReq.wdata,
                                             cfgReq.be);
        OFF_COR_MASK: st_nxt.corMask = merge(st_r.corMask, cfgReq.wdata,
                                             cfgReq.be);
        OFF_AER_CTRL: st_nxt.aerCtrl = merge(st_r.aerCtrl, cfgReq.wdata,
                                             cfgReq.be);
        OFF_PVC_CTST: st_nxt.pvcCtrl = merge(st_r.pvcCtrl, cfgReq.wdata,
                                             cfgReq.be);
        OFF_VC0_CTRL: st_nxt.vc0Ctrl = merge(st_r.vc0Ctrl, cfgReq.wdata,
                                             cfgReq.be);
        OFF_VC1_CTRL: st_nxt.vc1Ctrl = merge(st_r.vc1Ctrl, cfgReq.wdata,
                                             cfgReq.be);
        OFF_PWR_SEL:  st_nxt.pwrSel  = merge(st_r.pwrSel, cfgReq.wdata,
                                             cfgReq.be);
        OFF_ACS_CTRL: st_nxt.acsCtrl = merge(st_r.acsCtrl, cfgReq.wdata,
                                             cfgReq.be);
        OFF_EGRESS:   st_nxt.egress  = merge(st_r.egress, cfgReq.wdata,
                                             cfgReq.be);
        OFF_LTR_LAT:  st_nxt.ltrLat  = merge(st_r.ltrLat, cfgReq.wdata,
                                             cfgReq.be);
        default: begin
        end
      endcase
    end
    // Answer one cycle after request; log read adds one
    st_nxt.rsp.valid = 1'b0;
    st_nxt.logPend   = 1'b0;
    if (st_r.logPend) begin
      st_nxt.rsp.valid = 1'b1;
      st_nxt.rsp.hit   = 1'b1;
      st_nxt.rsp.rdata = hlogRdata;
    end else if (cfgReq.rd && isLog) begin
      st_nxt.logPend = 1'b1;
    end else if (cfgReq.rd || cfgReq.wr) begin
      st_nxt.rsp.valid = 1'b1;
      st_nxt.rsp.hit   = rdHit;
      st_nxt.rsp.rdata = cfgReq.rd ? rdMux : RESET_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstN_r) begin
    if (!rstN_r) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign cfgRsp     = st_r.rsp;
  assign vc1Control = st_r.vc1Ctrl;
  assign egressVec  = st_r.egress;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_LTR_END: assert property (@(posedge mclk)
    disable iff (!rstN_r)
    (cfgReq.rd && cfgReq.addr == OFF_LTR_HDR && !st_r.logPend) |=>
    (cfgRsp.valid && cfgRsp.rdata == 32'h0001_0018))
    else $error("LTR header wrong");
  AST_FIRST_HDR: assert property (@(posedge mclk)
    disable iff (!rstN_r)
    (cfgReq.rd && cfgReq.addr == OFF_AER_HDR && !st_r.logPend) |=>
    (cfgRsp.rdata == 32'h1401_0001))
    else $error("First header wrong");
  AST_CHAIN_UP: assert property (@(posedge mclk)
    disable iff (!rstN_r)
    (cfgReq.rd && cfgReq.addr == OFF_PWR_HDR && !st_r.logPend) |=>
    (cfgRsp.rdata[31:20] > 12'h0ff))
    else $error("Chain points below extended area");
  AST_VC_HDR: assert property (@(posedge mclk)
    disable iff (!rstN_r)
    (cfgReq.rd && cfgReq.addr == OFF_VC_HDR && !st_r.logPend) |=>
    (cfgRsp.rdata[15:0] == 16'h0002))
    else $error("VC header wrong");
  AST_VC1_WR: assert property (@(posedge mclk)
    disable iff (!rstN_r)
    (cfgReq.wr && cfgReq.addr == OFF_VC1_CTRL && cfgReq.be == 4'hf) |=>
    (vc1Control == $past(cfgReq.wdata)))
    else $error("VC1 control not written");
  AST_VENDOR_RO: assert property (@(posedge mclk)
    disable iff (!rstN_r)
    (st_r.strapped && !idLoad) |=> $stable(st_r.vendor))
    else $error("Vendor_identity changed");
  AST_HDR_VER: assert property (@(posedge mclk)
    disable iff (!rstN_r)
    (cfgReq.rd && cfgReq.addr == OFF_ACS_HDR && !st_r.logPend) |=>
    (cfgRsp.rdata[19:16] == 4'h1 && cfgRsp.rdata[31:20] == 12'h230))
    else $error("ACS header layout wrong");
  AST_STICKY: assert property (@(posedge mclk) disable iff (!rstN_r)
    (uncErrSet != 32'h0) |=> ((st_r.uncStat & $past(uncErrSet))
                              == $past(uncErrSet)))
    else $error("Error event lost");

endmodule
`default_nettype wire

// ===== rtl/pecfg_hlog_mem.sv
`timescale 1ns/1ns
`default_nettype none
module pecfg_hlog_mem #(
  parameter int DEPTH = 4
) (
  input  wire logic                     mclk,   // Core clock
  input  wire logic                     rstN,   // Synced reset
  input  wire logic                     we,     // Write strobe
  input  wire logic [$clog2(DEPTH)-1:0] waddr,  // Write word
  input  wire logic [31:0]              wdata,  // Write data
  input  wire logic [$clog2(DEPTH)-1:0] raddr,  // Read word
  output logic      [31:0]              rdata   // Registered data
);

  logic [31:0] mem [DEPTH];

  // ----------------------------------------------------------------
  // Storage with registered read
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      rdata <= 32'h0000_0000;
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= 32'h0000_0000;
      end
    end else begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end

endmodule
`default_nettype wire

// ===== rtl/pecfg_pkg.sv
package pecfg_pkg;

  // ----------------------------------------------------------------
  // Address map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_VENDOR      = 12'h000;
  localparam logic [11:0] OFF_AER_HDR     = 12'h100;
  localparam logic [11:0] OFF_UNC_STAT    = 12'h104;
  localparam logic [11:0] OFF_UNC_MASK    = 12'h108;
  localparam logic [11:0] OFF_UNC_SEV     = 12'h10c;
  localparam logic [11:0] OFF_COR_STAT    = 12'h110;
  localparam logic [11:0] OFF_COR_MASK    = 12'h114;
  localparam logic [11:0] OFF_AER_CTRL    = 12'h118;
  localparam logic [11:0] OFF_HLOG0       = 12'h11c;
  localparam logic [11:0] OFF_HLOG3       = 12'h128;
  localparam logic [11:0] OFF_VC_HDR      = 12'h140;
  localparam logic [11:0] OFF_PVC_CAP1    = 12'h144;
  localparam logic [11:0] OFF_PVC_CAP2    = 12'h148;
  localparam logic [11:0] OFF_PVC_CTST    = 12'h14c;
  localparam logic [11:0] OFF_VC0_CAP     = 12'h150;
  localparam logic [11:0] OFF_VC0_CTRL    = 12'h154;
  localparam logic [11:0] OFF_VC0_STAT    = 12'h158;
  localparam logic [11:0] OFF_VC1_CAP     = 12'h15c;
  localparam logic [11:0] OFF_VC1_CTRL    = 12'h160;
  localparam logic [11:0] OFF_VC1_STAT    = 12'h164;
  localparam logic [11:0] OFF_PWR_HDR     = 12'h20c;
  localparam logic [11:0] OFF_PWR_SEL     = 12'h210;
  localparam logic [11:0] OFF_PWR_CAP     = 12'h21c;
  localparam logic [11:0] OFF_ACS_HDR     = 12'h220;
  localparam logic [11:0] OFF_ACS_CTRL    = 12'h224;
  localparam logic [11:0] OFF_EGRESS      = 12'h228;
  localparam logic [11:0] OFF_LTR_HDR     = 12'h230;
  localparam logic [11:0] OFF_LTR_LAT     = 12'h234;
  localparam logic [11:0] EXT_BASE        = 12'h100;

  // ----------------------------------------------------------------
  // Capability identifiers and links
  // ----------------------------------------------------------------
  localparam logic [15:0] CAPID_AER       = 16'h0001;
  localparam logic [15:0] CAPID_VC        = 16'h0002;
  localparam logic [15:0] CAPID_PWR       = 16'h0004;
  localparam logic [15:0] CAPID_ACS       = 16'h000d;
  localparam logic [15:0] CAPID_LTR       = 16'h0018;
  localparam logic [3:0]  CAP_VERSION     = 4'h1;
  localparam logic [11:0] NEXT_END        = 12'h000;
  localparam logic [2:0]  VC_EXT_COUNT    = 3'h1;
  localparam logic [31:0] RESET_ZERO      = 32'h0000_0000;
  localparam logic [15:0] VENDOR_DEFAULT  = 16'h1a2b; // Arbitrary value

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pecfg_req_type;

  typedef struct packed {
    logic        valid;
    logic        hit;
    logic [31:0] rdata;
  } pecfg_rsp_type;

  // Builds an enhanced capability header
  function automatic logic [31:0] ext_hdr(input logic [15:0] id,
                                          input logic [11:0] nxt);
    ext_hdr = {nxt, CAP_VERSION, id};
  endfunction

endpackage

// ===== tb/pecfg_ext_space_bench.sv
`timescale 1ns/1ns
`default_nettype none
module pecfg_ext_space_bench
  import pecfg_pkg::*;
;
  logic          mclk = 1'b0;
  logic          arst_n;
  pecfg_req_type cfgReq;
  pecfg_rsp_type cfgRsp;
  logic          idLoad;
  logic [15:0]   idLoadVal;
  logic [31:0]   uncErrSet;
  logic [31:0]   corErrSet;
  logic          hlogWe;
  logic [1:0]    hlogIdx;
  logic [31:0]   hlogData;
  logic [31:0]   vc1Control;
  logic [31:0]   egressVec;
  int            badCount = 0;
  int            totalChecks = 0;

  // 25 MHz clock
  always #20 mclk = ~mclk;

  pecfg_ext_space dut (.mclk(mclk), .arst_n(arst_n), .cfgReq(cfgReq),
    .cfgRsp(cfgRsp), .idLoad(idLoad), .idLoadVal(idLoadVal),
    .uncErrSet(uncErrSet), .corErrSet(corErrSet), .hlogWe(hlogWe),
    .hlogIdx(hlogIdx), .hlogData(hlogData), .vc1Control(vc1Control),
    .egressVec(egressVec));

  pecfg_root_model root (.mclk(mclk), .cfgReq(cfgReq), .cfgRsp(cfgRsp));

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    totalChecks++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got,
               exp);
    end
  endtask

  // Read and compare the masked word and the hit flag
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
                        input logic eh, input logic [31:0] m);
    logic        h;
    logic        ok;
    logic [31:0] d;
    root.access(1'b0, a, 4'h0, 32'h0, h, d, ok);
    check({30'h0, ok, h}, {30'h0, 1'b1, eh}, "read answer");
    check(d & m, exp, "read data");
  endtask

  task automatic wr(input logic [11:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    logic        h;
    logic        ok;
    logic [31:0] x;
    root.access(1'b1, a, be, d, h, x, ok);
    check({31'h0, ok}, 32'h1, "write answer");
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  // Identity: default, refused config write, sideband load
  task automatic t_vendor;
    rd_chk(12'h000, {16'h0, VENDOR_DEFAULT}, 1'b1, 32'hffff);
    wr(12'h000, 4'hf, 32'h0000_e5e5);
    rd_chk(12'h000, {16'h0, VENDOR_DEFAULT}, 1'b1, 32'hffff);
    @(negedge mclk);
    idLoad = 1'b1;
    idLoadVal = 16'h5c3d;
    @(negedge mclk);
    idLoad = 1'b0;
    idLoadVal = 16'ha3c2;
    rd_chk(12'h000, 32'h5c3d, 1'b1, 32'hffff);
  endtask

  // Walk the capability chain from 100h to its end
  task automatic t_chain;
    rd_chk(12'h100, 32'h1401_0001, 1'b1, '1);
    rd_chk(12'h140, 32'h20c1_0002, 1'b1, '1);
    rd_chk(12'h20c, 32'h2201_0004, 1'b1, '1);
    rd_chk(12'h220, 32'h2301_000d, 1'b1, '1);
    rd_chk(12'h230, 32'h0001_0018, 1'b1, '1);
    // Header refuses a write, latency word takes one
    wr(12'h230, 4'hf, 32'hffff_ffff);
    rd_chk(12'h230, 32'h0001_0018, 1'b1, '1);
    wr(12'h234, 4'hf, 32'h1234_5678);
    rd_chk(12'h234, 32'h1234_5678, 1'b1, '1);
  endtask

  // Second channel control, byte lanes, egress vector
  task automatic t_vc1;
    wr(12'h160, 4'hf, 32'h8000_00a5);
    check(vc1Control, 32'h8000_00a5, "channel 1 output");
    wr(12'h160, 4'h1, 32'h0000_005a);
    wr(12'h154, 4'hf, 32'h1111_1111);
    rd_chk(12'h160, 32'h8000_005a, 1'b1, '1);
    rd_chk(12'h154, 32'h1111_1111, 1'b1, '1);
    wr(12'h228, 4'h6, 32'hffff_ffff);
    check(egressVec, 32'h00ff_ff00, "egress output");
  endtask

  // Sticky error bits, partial clear, unmapped place, header log
  task automatic t_err;
    @(negedge mclk);
    uncErrSet = 32'h10;
    corErrSet = 32'h41;
    @(negedge mclk);
    uncErrSet = 32'h0;
    corErrSet = 32'h0;
    rd_chk(12'h104, 32'h10, 1'b1, '1);
    wr(12'h104, 4'hf, 32'h10);
    rd_chk(12'h104, 32'h0, 1'b1, '1);
    wr(12'h110, 4'h1, 32'h01);
    rd_chk(12'h110, 32'h40, 1'b1, '1);
    rd_chk(12'h300, 32'h0, 1'b0, '1);
    hlogIdx = 2'h2;
    hlogData = 32'hcafe_0123;
    hlogWe = 1'b1;
    @(negedge mclk);
    hlogWe = 1'b0;
    rd_chk(12'h124, 32'hcafe_0123, 1'b1, '1);
  endtask

  // Mid-run reset clears controls and restores identity
  task automatic t_reset;
    @(negedge mclk);
    arst_n = 1'b0;
    repeat (2) @(negedge mclk);
    check(vc1Control | egressVec, 32'h0, "outputs in reset");
    arst_n = 1'b1;
    repeat (4) @(negedge mclk);
    rd_chk(12'h000, {16'h0, VENDOR_DEFAULT}, 1'b1, 32'hffff);
    rd_chk(12'h160, 32'h0, 1'b1, '1);
    rd_chk(12'h234, 32'h0, 1'b1, '1);
    rd_chk(12'h104, 32'h0, 1'b1, '1);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #(40 * 5000);
    badCount++;
    report_and_stop;
  end

  // Main sequence
  initial begin
    arst_n = 1'b0;
    idLoad = 1'b0;
    idLoadVal = 16'h0;
    uncErrSet = 32'h0;
    corErrSet = 32'h0;
    hlogWe = 1'b0;
    hlogIdx = 2'h0;
    hlogData = 32'h0;
    repeat (5) @(negedge mclk);
    check(vc1Control | egressVec | {31'h0, cfgRsp.valid}, 32'h0,
          "outputs in reset");
    arst_n = 1'b1;
    repeat (4) @(negedge mclk);
    t_vendor;
    t_chain;
    t_vc1;
    t_err;
    t_reset;
    report_and_stop;
  end
endmodule
`default_nettype wire

// ===== tb/pecfg_root_model.sv
`timescale 1ns/1ns
`default_nettype none
// --------------------------------------------------------------
// Upstream requester issuing configuration accesses
// --------------------------------------------------------------
module pecfg_root_model
  import pecfg_pkg::*;
(
  input  wire logic          mclk,    // Core clock
  output var  pecfg_req_type cfgReq,  // Request to the port
  input  wire pecfg_rsp_type cfgRsp   // Answer from the port
);
  // Idle request at time zero
  initial cfgReq = '0;

  // One access: one-cycle strobe, then a bounded wait for the answer
  task automatic access(input logic wr, input logic [11:0] addr,
                        input logic [3:0] be, input logic [31:0] wd,
                        output logic hit, output logic [31:0] rd,
                        output logic ok);
    @(negedge mclk);
    cfgReq = '{rd: !wr, wr: wr, addr: addr, be: be, wdata: wd};
    @(negedge mclk);
    // Released lines show garbage, never the old value
    cfgReq = '{rd: 1'b0, wr: 1'b0, addr: ~addr, be: ~be, wdata: ~wd};
    ok = 1'b0;
    hit = 1'b0;
    rd = '0;
    for (int n = 0; n < 4 && !ok; n++) begin
      if (cfgRsp.valid === 1'b1) begin
        ok = 1'b1;
        hit = cfgRsp.hit;
        rd = cfgRsp.rdata;
      end else begin
        @(negedge mclk);
      end
    end
    // Idle cycle so a log read never meets the next request
    @(negedge mclk);
  endtask
endmodule
`default_nettype wire
